// [hdl/dia_irq_activation.sv]
// interrupt acceptance and transfer-controller activation with lite register slave
// Functional notes
// - Per-vector transfer enables and the software interrupt register live in this unit.
// - Writing the software trigger bit raises a software request that takes the normal path.
// - A transfer that asks for a processor interrupt raises one for the vector that started it.
// - A peripheral request reaches the processor only with global enable, source enable and peripheral enable.
// - A maskable request is taken only if its level is strictly above the processor level.
// - Each source's level comes from its own priority register, not a fixed order.
// - Request flags of all sources, including the non-maskable one, are held here.
// - Maskable sources use the source enable register, the non-maskable one its own enable.
// - The processor level reads zero after reset, so with global enable any source whose level is above zero is admitted.
// - The global enable flag is zero after reset, masking all maskable requests.
// - Writing the global flag to one admits maskable requests, zero masks them.
// - Clearing the read-skip control bit resets the skip flag so information is read afresh.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
module dia_irq_activation #(
   parameter int NUM_SRC = 8,
   parameter int NS = NUM_SRC + 1,
   parameter int VW = $clog2(NS)
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [NUM_SRC-1:0] periph_req, // peripheral request pulses
   input wire logic [NUM_SRC-1:0] periph_req_en, // peripheral request enable bits
   input wire logic nmi_pin, // external non-maskable pin
   output logic cpu_irq, // request to processor
   output logic [VW-1:0] cpu_vec, // vector of that request
   output logic [3:0] cpu_level, // level of that request
   input wire logic cpu_ack, // processor takes the request
   output logic nmi_irq, // non-maskable request to processor
   input wire logic nmi_ack, // processor takes the nmi
   output logic xfer_req, // activation request to transfer controller
   output logic [VW-1:0] xfer_vec, // vector that activates it
   output logic xfer_skip, // information read may be skipped
   input wire logic xfer_ack, // transfer controller takes activation
   input wire logic xfer_done, // transfer sequence ended
   input wire logic xfer_cpu_irq // with done: processor interrupt wanted
);
   localparam int SWI = NUM_SRC; // software source index

   logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic wr_do, wr_ok, rd_ok;
   logic [31:0] rd_val;
   logic gie_q, rrs_q, nonmaskable_enable_reg_q, skip_q, nmi_flag_q, xfer_skip_q;
   logic [3:0] ipl_q;
   logic [NS-1:0] ier_q, dte_q, pend_q, post_q, pend_set, pend_clr, cpu_cand, xfer_cand;
   logic [3:0] prio_q [NS];
   logic sw_trig, nmi_s1_q, nmi_s2_q, nmi_s3_q;
   dia_pkg::dia_tc_state_t tc_q;
   logic xfer_req_q, cpu_irq_q;
   logic [VW-1:0] xfer_vec_q, cpu_vec_q, cpu_sel, xfer_sel;
   logic [3:0] cpu_level_q, cpu_best, xfer_best;
   logic cpu_any, xfer_any;

   // merge written bytes into an old word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   // map a byte address to a priority entry
   function automatic logic prio_hit(input logic [7:0] a, input int i);
      return a == 8'(int'(dia_pkg::OFS_PRIO) + 4 * i);
   endfunction : prio_hit

   assign wr_do = aw_got_q && w_got_q && !bvalid_q;

   // write channels: take address and data in any order, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= dia_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready_q) begin
            aw_got_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready_q) begin
            w_got_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_do) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? dia_pkg::RESP_OKAY : dia_pkg::RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // write decode: known offsets answer okay
   always_comb begin
      wr_ok = awaddr_q inside {dia_pkg::OFS_PSW, dia_pkg::OFS_IER, dia_pkg::OFS_DTE,
                               dia_pkg::OFS_SWI, dia_pkg::OFS_NONMASKABLE_ENABLE_REG, dia_pkg::OFS_SKIPCTL,
                               dia_pkg::OFS_PEND, dia_pkg::OFS_STAT};
      for (int i = 0; i < NS; i++) begin
         if (prio_hit(awaddr_q, i)) begin
            wr_ok = 1'b1;
         end
      end
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (araddr)
         dia_pkg::OFS_PSW: begin
            rd_val[dia_pkg::PSW_GIE_BIT] = gie_q;
            rd_val[dia_pkg::PSW_IPL_LSB +: dia_pkg::IPL_W] = ipl_q;
         end
         dia_pkg::OFS_IER: rd_val[NS-1:0] = ier_q;
         dia_pkg::OFS_DTE: rd_val[NS-1:0] = dte_q;
         dia_pkg::OFS_SWI: rd_val[dia_pkg::SWI_TRIG_BIT] = pend_q[SWI];
         dia_pkg::OFS_NONMASKABLE_ENABLE_REG: rd_val[dia_pkg::NONMASKABLE_ENABLE_REG_BIT] = nonmaskable_enable_reg_q;
         dia_pkg::OFS_SKIPCTL: rd_val[dia_pkg::RRS_BIT] = rrs_q;
         dia_pkg::OFS_PEND: rd_val[NS-1:0] = pend_q | post_q;
         dia_pkg::OFS_STAT: begin
            rd_val[dia_pkg::STAT_NMI_BIT] = nmi_flag_q;
            rd_val[dia_pkg::STAT_SKIP_BIT] = skip_q;
            rd_val[dia_pkg::STAT_BUSY_BIT] = tc_q != dia_pkg::TC_IDLE;
            rd_val[dia_pkg::STAT_CPU_BIT] = cpu_irq_q;
         end
         default: rd_ok = 1'b0;
      endcase
      for (int i = 0; i < NS; i++) begin
         if (prio_hit(araddr, i)) begin
            rd_val[3:0] = prio_q[i];
            rd_ok = 1'b1;
         end
      end
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= dia_pkg::RESP_OKAY;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_ok ? rd_val : 32'h0000_0000;
         rresp_q <= rd_ok ? dia_pkg::RESP_OKAY : dia_pkg::RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // control registers written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gie_q <= dia_pkg::GIE_RESET;
         ipl_q <= dia_pkg::IPL_RESET;
         ier_q <= '0;
         dte_q <= '0;
         nonmaskable_enable_reg_q <= 1'b0;
         rrs_q <= dia_pkg::RRS_RESET;
      end else if (wr_do) begin
         if (awaddr_q == dia_pkg::OFS_PSW && wstrb_q[0]) begin
            gie_q <= wdata_q[dia_pkg::PSW_GIE_BIT];
            ipl_q <= wdata_q[dia_pkg::PSW_IPL_LSB +: dia_pkg::IPL_W];
         end
         if (awaddr_q == dia_pkg::OFS_IER) begin
            ier_q <= NS'(wmerge(32'(ier_q), wdata_q, wstrb_q));
         end
         if (awaddr_q == dia_pkg::OFS_DTE) begin
            dte_q <= NS'(wmerge(32'(dte_q), wdata_q, wstrb_q));
         end
         if (awaddr_q == dia_pkg::OFS_NONMASKABLE_ENABLE_REG && wstrb_q[0] && wdata_q[dia_pkg::NONMASKABLE_ENABLE_REG_BIT]) begin
            nonmaskable_enable_reg_q <= 1'b1;
         end
         if (awaddr_q == dia_pkg::OFS_SKIPCTL && wstrb_q[0]) begin
            rrs_q <= wdata_q[dia_pkg::RRS_BIT];
         end
      end
   end

   // per-source priority entries
   for (genvar g = 0; g < NS; g++) begin : g_prio
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            prio_q[g] <= dia_pkg::PRIO_RESET;
         end else if (wr_do && wstrb_q[0] && prio_hit(awaddr_q, g)) begin
            prio_q[g] <= wdata_q[3:0];
         end
      end
   end

   // software trigger and request flag set and clear terms
   assign sw_trig = wr_do && awaddr_q == dia_pkg::OFS_SWI && wstrb_q[0] &&
                    wdata_q[dia_pkg::SWI_TRIG_BIT];
   always_comb begin
      pend_set = {sw_trig, periph_req & periph_req_en};
      pend_clr = '0;
      if (wr_do && awaddr_q == dia_pkg::OFS_PEND) begin
         pend_clr = NS'(wmerge(32'h0000_0000, wdata_q, wstrb_q));
      end
      if (tc_q == dia_pkg::TC_IDLE && xfer_any) begin
         pend_clr[xfer_sel] = 1'b1;
      end
      if (cpu_irq_q && cpu_ack) begin
         pend_clr[cpu_vec_q] = 1'b1;
      end
   end

   // request flags of every maskable source; a new event beats a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~pend_clr) | pend_set;
      end
   end

   // processor requests owed by finished transfers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         post_q <= '0;
      end else begin
         if (cpu_irq_q && cpu_ack) begin
            post_q[cpu_vec_q] <= 1'b0;
         end
         if (tc_q == dia_pkg::TC_BUSY && xfer_done && xfer_cpu_irq) begin
            post_q[xfer_vec_q] <= 1'b1;
         end
      end
   end

   // pick the highest-level candidate for each path, lowest index on a tie
   always_comb begin
      xfer_cand = pend_q & ier_q & dte_q;
      cpu_cand = '0;
      cpu_any = 1'b0;
      cpu_sel = '0;
      cpu_best = 4'h0;
      xfer_any = 1'b0;
      xfer_sel = '0;
      xfer_best = 4'h0;
      for (int i = 0; i < NS; i++) begin
         cpu_cand[i] = gie_q && prio_q[i] > ipl_q &&
                       ((pend_q[i] && ier_q[i] && !dte_q[i]) || post_q[i]);
         if (cpu_cand[i] && (!cpu_any || prio_q[i] > cpu_best)) begin
            cpu_any = 1'b1;
            cpu_sel = VW'(i);
            cpu_best = prio_q[i];
         end
         if (xfer_cand[i] && (!xfer_any || prio_q[i] > xfer_best)) begin
            xfer_any = 1'b1;
            xfer_sel = VW'(i);
            xfer_best = prio_q[i];
         end
      end
   end

   // processor request: held until taken, withdrawn if the global flag drops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq_q <= 1'b0;
         cpu_vec_q <= '0;
         cpu_level_q <= 4'h0;
      end else if (!cpu_irq_q) begin
         if (cpu_any) begin
            cpu_irq_q <= 1'b1;
            cpu_vec_q <= cpu_sel;
            cpu_level_q <= cpu_best;
         end
      end else if (cpu_ack || !gie_q) begin
         cpu_irq_q <= 1'b0;
      end
   end

   // transfer controller hand-off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tc_q <= dia_pkg::TC_IDLE;
         xfer_req_q <= 1'b0;
         xfer_vec_q <= '0;
      end else begin
         unique case (tc_q)
            dia_pkg::TC_IDLE: begin
               if (xfer_any) begin
                  tc_q <= dia_pkg::TC_REQ;
                  xfer_req_q <= 1'b1;
                  xfer_vec_q <= xfer_sel;
               end
            end
            dia_pkg::TC_REQ: begin
               if (xfer_ack) begin
                  tc_q <= dia_pkg::TC_BUSY;
                  xfer_req_q <= 1'b0;
               end
            end
            dia_pkg::TC_BUSY: begin
               if (xfer_done) begin
                  tc_q <= dia_pkg::TC_IDLE;
               end
            end
         endcase
      end
   end

   // information read-skip flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_q <= 1'b0;
         xfer_skip_q <= 1'b0;
      end else begin
         if (!rrs_q) begin
            skip_q <= 1'b0;
         end else if (tc_q == dia_pkg::TC_BUSY && xfer_done) begin
            skip_q <= 1'b1;
         end
         xfer_skip_q <= skip_q && rrs_q;
      end
   end

   // non-maskable pin: synchronise, detect rise, hold flag until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_s1_q <= 1'b0;
         nmi_s2_q <= 1'b0;
         nmi_s3_q <= 1'b0;
         nmi_flag_q <= 1'b0;
      end else begin
         nmi_s1_q <= nmi_pin;
         nmi_s2_q <= nmi_s1_q;
         nmi_s3_q <= nmi_s2_q;
         if (nmi_s2_q && !nmi_s3_q && nonmaskable_enable_reg_q) begin
            nmi_flag_q <= 1'b1;
         end else if (nmi_ack) begin
            nmi_flag_q <= 1'b0;
         end
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign cpu_irq = cpu_irq_q;
   assign cpu_vec = cpu_vec_q;
   assign cpu_level = cpu_level_q;
   assign nmi_irq = nmi_flag_q;
   assign xfer_req = xfer_req_q;
   assign xfer_vec = xfer_vec_q;
   assign xfer_skip = xfer_skip_q;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_gie_after_reset: assert property ($rose(aresetn) |-> !gie_q)
      else $error("global enable not clear after reset");
   a_ipl_after_reset: assert property ($rose(aresetn) |-> ipl_q == 4'h0)
      else $error("processor level not zero after reset");
   a_cpu_gate: assert property ($rose(cpu_irq_q) |-> $past(gie_q)
      && $past(ier_q[cpu_sel] || post_q[cpu_sel]))
      else $error("processor request without enables");
   a_level_above: assert property ($rose(cpu_irq_q) |-> cpu_level_q > $past(ipl_q)
      && cpu_level_q == prio_q[cpu_vec_q])
      else $error("processor request level not above processor level");
   a_swi_sets: assert property (sw_trig |=> pend_q[SWI] || xfer_req_q || cpu_irq_q)
      else $error("software trigger lost");
   a_post_raise: assert property (tc_q == dia_pkg::TC_BUSY && xfer_done && xfer_cpu_irq
      && !(cpu_irq_q && cpu_ack && cpu_vec_q == xfer_vec_q) |=> post_q[$past(xfer_vec_q)])
      else $error("finished transfer did not raise processor request");
   a_skip_clear: assert property (!rrs_q |=> !skip_q ##1 !xfer_skip_q)
      else $error("skip flag survives clear of control bit");
   a_nmi_enable: assert property ($rose(nmi_flag_q) |-> $past(nonmaskable_enable_reg_q))
      else $error("nmi flag set while not enabled");
   a_src_flag: assert property (periph_req[0] && periph_req_en[0] |=> pend_q[0])
      else $error("peripheral event not held");
   a_no_cpu_dte: assert property ($rose(cpu_irq_q) |-> !dte_q[cpu_vec_q]
      || $past(post_q[cpu_sel]))
      else $error("transfer-enabled source sent to processor");
   a_gie_write: assert property (wr_do && awaddr_q == dia_pkg::OFS_PSW && wstrb_q[0]
      |=> gie_q == $past(wdata_q[dia_pkg::PSW_GIE_BIT]))
      else $error("global flag write not applied");
   a_xfer_hold: assert property (xfer_req_q && !xfer_ack |=> xfer_req_q && $stable(xfer_vec_q))
      else $error("activation request dropped early");

   c_cpu_taken: cover property (cpu_irq_q && cpu_ack);
   c_xfer_post: cover property (tc_q == dia_pkg::TC_BUSY && xfer_done && xfer_cpu_irq);
   c_nmi_seen: cover property ($rose(nmi_flag_q));
   c_swi_xfer: cover property (sw_trig ##[1:20] xfer_req_q);
endmodule : dia_irq_activation

// [common/dia_pkg.sv]
// constants, offsets and types shared by the interrupt activation block
package dia_pkg;
   // register byte offsets on the lite bus
   localparam logic [7:0] OFS_PSW = 8'h00;
   localparam logic [7:0] OFS_IER = 8'h04;
   localparam logic [7:0] OFS_DTE = 8'h08;
   localparam logic [7:0] OFS_SWI = 8'h0C;
   localparam logic [7:0] OFS_NONMASKABLE_ENABLE_REG = 8'h10;
   localparam logic [7:0] OFS_SKIPCTL = 8'h14;
   localparam logic [7:0] OFS_PEND = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   localparam logic [7:0] OFS_PRIO = 8'h40;
   // field positions
   localparam int PSW_GIE_BIT = 0;
   localparam int PSW_IPL_LSB = 4;
   localparam int IPL_W = 4;
   localparam int SWI_TRIG_BIT = 0;
   localparam int NONMASKABLE_ENABLE_REG_BIT = 0;
   localparam int RRS_BIT = 0;
   localparam int STAT_NMI_BIT = 0;
   localparam int STAT_SKIP_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int STAT_CPU_BIT = 3;
   // reset values
   localparam logic GIE_RESET = 1'b0;
   localparam logic [3:0] IPL_RESET = 4'h0;
   localparam logic [3:0] PRIO_RESET = 4'h0;
   localparam logic RRS_RESET = 1'b0;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // transfer controller hand-off states
   typedef enum logic [1:0] {TC_IDLE, TC_REQ, TC_BUSY} dia_tc_state_t;
endpackage : dia_pkg

// [verification/dia_far_model.sv]
// far-side model: processor core and transfer controller answering the block
module dia_far_model (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [1:0] dly, // extra answer delay in cycles
   input wire logic want_cpu, // ask for a processor interrupt at transfer end
   input wire logic cpu_irq, // maskable request
   output logic cpu_ack, // takes the maskable request
   input wire logic nmi_irq, // non-maskable request
   output logic nmi_ack, // takes the nmi
   input wire logic xfer_req, // activation request
   output logic xfer_ack, // takes the activation
   output logic xfer_done, // transfer sequence ended
   output logic xfer_cpu_irq // processor interrupt wanted at end
);
   timeunit 1ns;
   timeprecision 1ps;
   int cc;
   int xc;
   logic busy;
   // one answer pulse per request, the nmi on the next cycle, the others after the chosen delay; done never before ack
   always @(posedge aclk) begin
      if (!aresetn) begin
         cc <= 0;
         xc <= 0;
         busy <= 1'b0;
         cpu_ack <= 1'b0;
         nmi_ack <= 1'b0;
         xfer_ack <= 1'b0;
         xfer_done <= 1'b0;
         xfer_cpu_irq <= 1'b0;
      end else begin
         nmi_ack <= nmi_irq && !nmi_ack;
         cpu_ack <= cpu_irq && !cpu_ack && cc >= dly;
         if (cpu_irq && !cpu_ack) cc <= (cc >= dly) ? 0 : cc + 1;
         if (busy || (xfer_req && !xfer_ack)) xc <= (xc >= dly) ? 0 : xc + 1;
         xfer_ack <= xfer_req && !xfer_ack && !busy && xc >= dly;
         xfer_done <= busy && xc >= dly;
         xfer_cpu_irq <= busy && xc >= dly && want_cpu;
         if (xfer_req && !xfer_ack && !busy && xc >= dly) busy <= 1'b1;
         else if (busy && xc >= dly) busy <= 1'b0;
      end
   end
endmodule : dia_far_model

// [verification/dia_irq_activation_bench.sv]
// self-checking bench for the interrupt activation block
module dia_irq_activation_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, nmi_pin, cpu_irq, cpu_ack, nmi_irq, nmi_ack;
   logic xfer_req, xfer_skip, xfer_ack, xfer_done, xfer_cpu_irq, want_cpu, pc, px, pn;
   logic [7:0] awaddr, araddr, periph_req, periph_req_en;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, cpu_vec, cpu_level, xfer_vec, la, lb;
   logic [2:0] a, b;
   logic [1:0] bresp, rresp, dly;
   logic [35:0] q[5][$];
   int num_errors = 0;
   int cmp_count = 0;
   int seed = 32'h6975B977;
   int i;

   dia_irq_activation #(.NUM_SRC(8)) i_dia_irq_activation (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .periph_req,
      .periph_req_en, .nmi_pin, .cpu_irq, .cpu_vec, .cpu_level, .cpu_ack, .nmi_irq,
      .nmi_ack, .xfer_req, .xfer_vec, .xfer_skip, .xfer_ack, .xfer_done, .xfer_cpu_irq);
   dia_far_model i_dia_far_model (.aclk, .aresetn, .dly, .want_cpu, .cpu_irq, .cpu_ack,
      .nmi_irq, .nmi_ack, .xfer_req, .xfer_ack, .xfer_done, .xfer_cpu_irq);

   task automatic test_done;
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // a result with no note waiting is compared against an impossible value
   task automatic take(input int k, input logic [35:0] v);
      if (q[k].size() == 0) chk(v, '1);
      else chk(v, q[k].pop_front());
   endtask : take

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   function automatic logic [7:0] pa(input int n);
      return 8'(dia_pkg::OFS_PRIO + 4 * n);
   endfunction : pa

   // lite write: address and data together, each released when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = 2'h0,
                     input logic [3:0] s = 4'hF);
      q[0].push_back(36'(r));
      awaddr <= ad;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) bready <= 1'b0;
      end while (bready);
   endtask : wr

   // lite read: data and response noted for the monitor
   task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = 2'h0);
      q[1].push_back({2'h0, r, d});
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) rready <= 1'b0;
      end while (rready);
   endtask : rd

   task automatic pulse(input logic [7:0] m);
      periph_req <= m;
      @(posedge aclk);
      periph_req <= 8'h00;
   endtask : pulse

   // wait for the noted events, then a quiet spell that catches extra ones
   task automatic settle;
      int n;
      for (n = 0; n < 200 && q[2].size() + q[3].size() + q[4].size() != 0; n++) begin
         @(posedge aclk);
      end
      cyc(12);
   endtask : settle

   // monitor: each result takes the oldest note of its kind
   always @(posedge aclk) begin
      if (aresetn) begin
         if (bvalid && bready) take(0, 36'(bresp));
         if (rvalid && rready) take(1, {2'h0, rresp, rdata});
         if (cpu_irq && !pc) take(2, 36'({cpu_vec, cpu_level}));
         if (xfer_req && !px) take(3, 36'({xfer_vec, xfer_skip}));
         if (nmi_irq && !pn) take(4, 36'h1);
      end
      pc <= cpu_irq;
      px <= xfer_req;
      pn <= nmi_irq;
   end

   // clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      test_done;
   end

   // main sequence
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, nmi_pin, want_cpu} = '0;
      {awaddr, araddr, periph_req, wdata, dly} = '0;
      wstrb = 4'hF;
      periph_req_en = 8'hFF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(dia_pkg::OFS_PSW, 32'h0);
      rd(pa(2), 32'h0);
      rd(8'h30, 32'h0, dia_pkg::RESP_SLVERR);
      wr(8'h30, 32'h1, dia_pkg::RESP_SLVERR);
      // held back while the global flag is clear, taken once it is set
      wr(dia_pkg::OFS_IER, 32'h1FF);
      wr(pa(2), 32'h3);
      pulse(8'h04);
      settle;
      rd(dia_pkg::OFS_PEND, 32'h4);
      q[2].push_back(36'h23);
      wr(dia_pkg::OFS_PSW, 32'h1);
      settle;
      // random pairs raised together: higher level first, lower index on a tie
      for (i = 0; i < 6; i++) begin
         dly <= 2'($random(seed));
         a = 3'($random(seed));
         b = a + 3'(1 + $unsigned($random(seed)) % 7);
         la = 4'(1 + $unsigned($random(seed)) % 15);
         lb = 4'(1 + $unsigned($random(seed)) % 15);
         wr(pa(a), 32'(la));
         wr(pa(b), 32'(lb));
         if (lb > la || (la == lb && b < a)) {a, b, la, lb} = {b, a, lb, la};
         q[2].push_back(36'({1'b0, a, la}));
         q[2].push_back(36'({1'b0, b, lb}));
         periph_req_en <= 8'($random(seed)) | (8'h01 << a) | (8'h01 << b);
         pulse((8'h01 << a) | (8'h01 << b));
         settle;
      end
      // peripheral enable off, then a level equal to the processor level
      wr(pa(4), 32'h3);
      periph_req_en <= 8'hEF;
      pulse(8'h10);
      settle;
      periph_req_en <= 8'hFF;
      wr(dia_pkg::OFS_PSW, 32'h31);
      pulse(8'h10);
      settle;
      q[2].push_back(36'h44);
      wr(pa(4), 32'h4);
      settle;
      wr(dia_pkg::OFS_PSW, 32'h1);
      // software trigger to the processor, then to the transfer controller
      wr(pa(8), 32'h2);
      q[2].push_back(36'h82);
      wr(dia_pkg::OFS_SWI, 32'h1);
      settle;
      wr(dia_pkg::OFS_DTE, 32'h100);
      q[3].push_back(36'h10);
      wr(dia_pkg::OFS_SWI, 32'h1);
      settle;
      // transfer that ends with a processor request for the same vector
      wr(dia_pkg::OFS_DTE, 32'h008);
      wr(pa(3), 32'h6);
      want_cpu <= 1'b1;
      q[3].push_back(36'h06);
      q[2].push_back(36'h36);
      pulse(8'h08);
      settle;
      want_cpu <= 1'b0;
      // read-skip: set by a done with skip on, reset by clearing the control bit
      for (i = 0; i < 4; i++) begin
         if (i != 1) wr(dia_pkg::OFS_SKIPCTL, 32'(i != 2));
         q[3].push_back(36'({4'h3, i == 1}));
         pulse(8'h08);
         settle;
      end
      // nmi ignored until its enable is set
      nmi_pin <= 1'b1;
      cyc(8);
      nmi_pin <= 1'b0;
      wr(dia_pkg::OFS_NONMASKABLE_ENABLE_REG, 32'h1);
      q[4].push_back(36'h1);
      nmi_pin <= 1'b1;
      settle;
      // software clear of a flag, status word, byte strobes, then a second reset
      wr(dia_pkg::OFS_PSW, 32'h0);
      pulse(8'h01);
      rd(dia_pkg::OFS_PEND, 32'h1);
      rd(dia_pkg::OFS_STAT, 32'h2);
      wr(dia_pkg::OFS_PEND, 32'h1);
      rd(dia_pkg::OFS_PEND, 32'h0);
      wr(dia_pkg::OFS_IER, 32'h0, dia_pkg::RESP_OKAY, 4'h2);
      rd(dia_pkg::OFS_IER, 32'hFF);
      wr(dia_pkg::OFS_PSW, 32'h51, dia_pkg::RESP_OKAY, 4'hE);
      rd(dia_pkg::OFS_PSW, 32'h0);
      wr(dia_pkg::OFS_PSW, 32'h51);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(dia_pkg::OFS_PSW, 32'h0);
      rd(pa(3), 32'h0);
      for (i = 0; i < 5; i++) chk(36'(q[i].size()), 36'h0);
      test_done;
   end
endmodule : dia_irq_activation_bench
